// ### rtl/pmi_command.v
// serial-bus slave command interpreter for a current and voltage monitor
// assumes SCL, SDA, address select and comparator inputs are asynchronous pins,
// and conversion results arrive from logic on SYS_CLK
`timescale 1ns/1ps
`include "pmi_consts.vh"

module pmi_command #(
    parameter CODE_W = 12                   // conversion result width
) (
    input  wire              SYS_CLK,         // system clock, 25 MHz
    input  wire              RST_N,           // synchronous reset, active low
    input  wire              SCL,             // bus clock pin
    input  wire              SDA_IN,          // bus data pin level
    output wire              SDA_OUT,         // bus data drive value, always low
    output reg               SDA_OE,          // pull data line low while high
    input  wire [1:0]        ADDR_SEL,        // address-select pin state
    input  wire              OC_PRESENT,      // overcurrent comparator output
    input  wire              TIMER_DONE,      // timer reached its threshold
    input  wire              CONV_DONE,       // conversion complete pulse
    input  wire              CONV_IS_AMP,     // completed conversion is current
    input  wire [CODE_W-1:0] CONV_CODE,       // completed conversion result
    input  wire [7:0]        READ_DATA,       // next readback byte from formatter
    output reg               READ_NEXT,       // pulse: READ_DATA taken
    output wire              VOLT_CONTINUOUS, // convert voltage continuously
    output wire              AMP_CONTINUOUS,  // convert current continuously
    output wire              VOLT_ONCE,       // single voltage conversion pending
    output wire              AMP_ONCE,        // single current conversion pending
    output wire              DIVIDER_SELECT,  // 0 fourteen-to-one, 1 seven-to-two
    output wire              STATUS_SELECT,   // reads return status byte
    output reg               ALERT            // alert output, active high
);

    localparam S_IDLE = 6'b000001;
    localparam S_ADDR = 6'b000010;
    localparam S_ACK  = 6'b000100;
    localparam S_WR   = 6'b001000;
    localparam S_RD   = 6'b010000;
    localparam S_RACK = 6'b100000;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bus condition detection

    wire [1:0] bus_s;
    wire [1:0] adr_s;
    wire [1:0] cmp_s;
    reg  [1:0] bus_d;

    // bus pins show idle high during reset, the other pins low
    pmi_sync #(.W(6), .RST_V(6'h30)) u_pin_sync (
        .clk  (SYS_CLK),
        .rst_n(RST_N),
        .din  ({SCL, SDA_IN, ADDR_SEL, OC_PRESENT, TIMER_DONE}),
        .dout ({bus_s, adr_s, cmp_s})
    );

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            bus_d <= 2'h3;
        end else begin
            bus_d <= bus_s;
        end
    end

    wire scl      = bus_s[1];
    wire sda      = bus_s[0];
    wire scl_rise = scl & ~bus_d[1];
    wire scl_fall = ~scl & bus_d[1];
    wire start_c  = scl & bus_d[1] & bus_d[0] & ~sda;
    wire stop_c   = scl & bus_d[1] & ~bus_d[0] & sda;
    wire [6:0] own_addr = {`PMI_ADDR_UPPER, adr_s};

    ////////////////////////////////////////////////////////////////////////////
    // registers and alert state

    reg [7:0] cmd;
    reg [7:0] alert_enable;
    reg [7:0] alert_threshold;
    reg [7:0] control;
    reg       data_valid;
    reg       adc_oc;
    reg       adc_alert;
    reg       comparator_fault_latch;
    reg       off_alert;
    reg [2:0] exceed_cnt;

    assign VOLT_CONTINUOUS = cmd[`PMI_CMD_VCONT];
    assign VOLT_ONCE       = cmd[`PMI_CMD_VONCE];
    assign AMP_CONTINUOUS  = cmd[`PMI_CMD_ACONT];
    assign AMP_ONCE        = cmd[`PMI_CMD_AONCE];
    assign DIVIDER_SELECT  = cmd[`PMI_CMD_DIVSEL];
    assign STATUS_SELECT   = cmd[`PMI_CMD_STATUS];
    assign SDA_OUT         = 1'b0;

    wire software_off   = control[0];
    wire arm_single     = alert_enable[`PMI_AEN_SINGLE];
    wire arm_quad       = alert_enable[`PMI_AEN_QUAD];
    wire arm_comp       = alert_enable[`PMI_AEN_COMP];
    wire arm_off        = alert_enable[`PMI_AEN_OFF];
    wire clear_req      = alert_enable[`PMI_AEN_CLEAR];
    wire once_pending   = VOLT_ONCE | AMP_ONCE;
    wire amp_done       = CONV_DONE & CONV_IS_AMP;
    wire exceed         = CONV_CODE[CODE_W-1:CODE_W-8] > alert_threshold;
    wire quad_hit       = arm_quad & (exceed_cnt >= (`PMI_QUAD_COUNT - 3'h1));
    wire set_adc        = amp_done & exceed & (arm_single | quad_hit);
    wire set_comp       = arm_comp & cmp_s[1] & cmp_s[0];
    wire set_off        = arm_off & software_off;

    wire [7:0] status_byte = {2'h0, off_alert, software_off, comparator_fault_latch,
                              cmp_s[1], adc_alert, adc_oc};

    ////////////////////////////////////////////////////////////////////////////
    // bus transfer state machine

    reg [5:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg [7:0] txreg;
    reg       is_read;
    reg [1:0] byte_idx;
    reg       master_ack;
    reg       cmd_pend;
    reg [7:0] cmd_byte;
    reg       sel_seen;
    reg [1:0] sel_code;
    reg       ext_pend;
    reg [7:0] ext_byte;

    wire commit = stop_c | start_c;

    // readback byte: status, zeros before first conversion, or formatter data
    wire [7:0] rd_byte = STATUS_SELECT ? status_byte :
                         (data_valid ? READ_DATA : 8'h00);

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state      <= S_IDLE;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            txreg      <= 8'h00;
            is_read    <= 1'b0;
            byte_idx   <= 2'h0;
            master_ack <= 1'b0;
            SDA_OE     <= 1'b0;
            READ_NEXT  <= 1'b0;
            cmd_pend   <= 1'b0;
            cmd_byte   <= 8'h00;
            sel_seen   <= 1'b0;
            sel_code   <= 2'h0;
            ext_pend   <= 1'b0;
            ext_byte   <= 8'h00;
        end else begin
            READ_NEXT <= 1'b0;
            if (commit) begin
                cmd_pend <= 1'b0;
                ext_pend <= 1'b0;
                sel_seen <= 1'b0;
                SDA_OE   <= 1'b0;
                bitcnt   <= 4'h0;
                byte_idx <= 2'h0;
                state    <= start_c ? S_ADDR : S_IDLE;
            end else begin
                case (state)
                    S_ADDR: begin
                        if (scl_rise) begin
                            shreg  <= {shreg[6:0], sda};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            is_read <= shreg[0];
                            if (shreg[7:1] == own_addr && !(shreg[0] && once_pending)) begin
                                SDA_OE <= 1'b1;
                                state  <= S_ACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (is_read) begin
                                txreg     <= rd_byte;
                                SDA_OE    <= ~rd_byte[7];
                                READ_NEXT <= ~STATUS_SELECT;
                                state     <= S_RD;
                            end else begin
                                SDA_OE <= 1'b0;
                                state  <= S_WR;
                            end
                        end
                    end
                    S_WR: begin
                        if (scl_rise) begin
                            shreg  <= {shreg[6:0], sda};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            if (byte_idx == 2'h0) begin
                                SDA_OE   <= 1'b1;
                                state    <= S_ACK;
                                byte_idx <= 2'h1;
                                if (!shreg[7]) begin
                                    cmd_pend <= 1'b1;
                                    cmd_byte <= shreg;
                                end else begin
                                    sel_seen <= 1'b1;
                                    sel_code <= shreg[1:0];
                                end
                            end else if (byte_idx == 2'h1 && sel_seen) begin
                                SDA_OE   <= 1'b1;
                                state    <= S_ACK;
                                byte_idx <= 2'h2;
                                ext_pend <= 1'b1;
                                ext_byte <= shreg;
                            end else begin
                                // bytes beyond the documented forms are refused
                                cmd_pend <= 1'b0;
                                ext_pend <= 1'b0;
                                state    <= S_IDLE;
                            end
                        end
                    end
                    S_RD: begin
                        if (scl_rise) begin
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                SDA_OE <= 1'b0;
                                state  <= S_RACK;
                            end else begin
                                txreg  <= {txreg[6:0], 1'b0};
                                SDA_OE <= ~txreg[6];
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            master_ack <= ~sda;
                        end else if (scl_fall) begin
                            bitcnt <= 4'h0;
                            if (master_ack) begin
                                txreg     <= rd_byte;
                                SDA_OE    <= ~rd_byte[7];
                                READ_NEXT <= ~STATUS_SELECT;
                                state     <= S_RD;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    default: begin
                        SDA_OE <= 1'b0;
                        state  <= S_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command and extended registers

    wire load_cmd = commit & cmd_pend;
    wire load_ext = commit & ext_pend;

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cmd             <= `PMI_RST_CMD;
            alert_enable    <= `PMI_RST_ALERT_EN;
            alert_threshold <= `PMI_RST_THRESHOLD;
            control         <= `PMI_RST_CONTROL;
            data_valid      <= 1'b0;
        end else begin
            if (load_cmd) begin
                cmd <= {1'b0, cmd_byte[6:0]};
            end else begin
                // one-shot requests drop when their conversion completes
                if (CONV_DONE && !CONV_IS_AMP) begin
                    cmd[`PMI_CMD_VONCE] <= 1'b0;
                end
                if (amp_done) begin
                    cmd[`PMI_CMD_AONCE] <= 1'b0;
                end
            end
            if (load_cmd && (cmd_byte[`PMI_CMD_VCONT] || cmd_byte[`PMI_CMD_ACONT])) begin
                data_valid <= 1'b0;
            end else if (CONV_DONE) begin
                data_valid <= 1'b1;
            end
            if (load_ext && sel_code == `PMI_SEL_ALERT_EN) begin
                alert_enable <= ext_byte;
            end else if (clear_req) begin
                alert_enable[`PMI_AEN_CLEAR] <= 1'b0;
            end
            if (load_ext && sel_code == `PMI_SEL_THRESHOLD) begin
                alert_threshold <= ext_byte;
            end
            if (load_ext && sel_code == `PMI_SEL_CONTROL) begin
                control <= ext_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alert latches and output

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            exceed_cnt             <= 3'h0;
            adc_oc                 <= 1'b0;
            adc_alert              <= 1'b0;
            comparator_fault_latch <= 1'b0;
            off_alert              <= 1'b0;
            ALERT                  <= 1'b0;
        end else begin
            if (amp_done) begin
                adc_oc <= exceed;
                if (!exceed) begin
                    exceed_cnt <= 3'h0;
                end else if (exceed_cnt < `PMI_QUAD_COUNT) begin
                    exceed_cnt <= exceed_cnt + 3'h1;
                end
            end
            // set wins over clear so a persisting source re-latches at once
            if (set_adc) begin
                adc_alert <= 1'b1;
            end else if (clear_req) begin
                adc_alert <= 1'b0;
            end
            if (set_comp) begin
                comparator_fault_latch <= 1'b1;
            end else if (clear_req) begin
                comparator_fault_latch <= 1'b0;
            end
            if (set_off) begin
                off_alert <= 1'b1;
            end else if (clear_req) begin
                off_alert <= 1'b0;
            end
            ALERT <= (adc_alert | comparator_fault_latch) & ~(arm_off & software_off);
        end
    end

endmodule // pmi_command

// ### rtl/pmi_consts.vh
// constants for the power monitor command interpreter
// assumes inclusion by bare name from the design files
`ifndef PMI_CONSTS_VH
`define PMI_CONSTS_VH

// bus address: upper five bits fixed, two low bits from the select pin
`define PMI_ADDR_UPPER     5'h0B

// register-select byte codes (low two bits)
`define PMI_SEL_ALERT_EN   2'h1
`define PMI_SEL_THRESHOLD  2'h2
`define PMI_SEL_CONTROL    2'h3

// command byte bit positions
`define PMI_CMD_VCONT      0
`define PMI_CMD_VONCE      1
`define PMI_CMD_ACONT      2
`define PMI_CMD_AONCE      3
`define PMI_CMD_DIVSEL     4
`define PMI_CMD_SPARE      5
`define PMI_CMD_STATUS     6

// alert-enable bit positions
`define PMI_AEN_SINGLE     0
`define PMI_AEN_QUAD       1
`define PMI_AEN_COMP       2
`define PMI_AEN_OFF        3
`define PMI_AEN_CLEAR      4

// status byte bit positions
`define PMI_ST_ADC_OC      0
`define PMI_ST_ADC_ALERT   1
`define PMI_ST_OC          2
`define PMI_ST_COMP_ALERT  3
`define PMI_ST_OFF         4
`define PMI_ST_OFF_ALERT   5

// reset values
`define PMI_RST_CMD        8'h00
`define PMI_RST_ALERT_EN   8'h04
`define PMI_RST_THRESHOLD  8'hFF
`define PMI_RST_CONTROL    8'h00

// consecutive exceedances for the quad trip
`define PMI_QUAD_COUNT     3'h4

`endif

// ### rtl/pmi_sync.v
// two-flop synchroniser for a group of level inputs
// assumes inputs are asynchronous to clk; reset is synchronous, active low
`timescale 1ns/1ps

module pmi_sync #(
    parameter W     = 1,                // number of bits
    parameter RST_V = 0                 // value shown during reset
) (
    input  wire         clk,            // sampling clock
    input  wire         rst_n,          // synchronous reset, active low
    input  wire [W-1:0] din,            // asynchronous inputs
    output reg  [W-1:0] dout            // synchronised outputs
);

    reg [W-1:0] stage1;

    always @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= RST_V[W-1:0];
            dout   <= RST_V[W-1:0];
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule // pmi_sync

// ### verif/pmi_bus_master.sv
// serial bus master model: drives the bus clock and pulls the data line low
// assumes sda_in is the wired data level with a pull-up; clk is the system clock
`timescale 1ns/1ps

module pmi_bus_master (
    input  wire        clk,    // bench system clock
    input  wire        sda_in, // wired data level
    output reg         scl,    // bus clock, still high outside frames
    output reg         sda_oe, // pulls data low while high
    output reg  [7:0]  rd,     // last ack bit or byte received
    output reg  [15:0] res_n   // counts results received
);
    reg s;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
        rd = 8'h00;
        res_n = 16'h0000;
    end

    // quarter of a 320 ns bus clock period
    task q;
        repeat (2) @(negedge clk);
    endtask

    task start;
        sda_oe = 1'b1;
        q;
        q;
        scl = 1'b0;
    endtask

    task stop;
        q;
        sda_oe = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_oe = 1'b0;
        q;
        q;
    endtask

    task bitx(input b);
        q;
        sda_oe = !b;
        q;
        scl = 1'b1;
        q;
        s = sda_in;
        q;
        scl = 1'b0;
    endtask

    // one byte plus its acknowledge; rx reads and answers with last
    task xbyte(input [7:0] b, input rx, input last);
        integer   i;
        reg [7:0] d;
        for (i = 7; i >= 0; i = i - 1) begin
            bitx(b[i]);
            d[i] = s;
        end
        bitx(rx ? last : 1'b1);
        rd = rx ? d : {7'h00, s};
        res_n = res_n + 16'h0001;
    endtask
endmodule // pmi_bus_master

// ### verif/pmi_command_props.sv
// checker on the command interpreter ports: bus drive, reset, one-shot and alert timing
// assumes binding onto pmi_command with SDA_IN carrying the wired data level
`timescale 1ns/1ps

module pmi_command_props #(
    parameter CODE_W = 12                    // conversion result width
) (
    input wire              SYS_CLK,         // system clock
    input wire              RST_N,           // synchronous reset, active low
    input wire              SCL,             // bus clock pin
    input wire              SDA_IN,          // wired data level
    input wire              SDA_OUT,         // data drive value
    input wire              SDA_OE,          // data pull-down enable
    input wire [1:0]        ADDR_SEL,        // address select
    input wire              OC_PRESENT,      // overcurrent level
    input wire              TIMER_DONE,      // timer level
    input wire              CONV_DONE,       // conversion pulse
    input wire              CONV_IS_AMP,     // current channel
    input wire [CODE_W-1:0] CONV_CODE,       // conversion result
    input wire [7:0]        READ_DATA,       // readback byte
    input wire              READ_NEXT,       // byte taken
    input wire              VOLT_CONTINUOUS, // command bit 0
    input wire              AMP_CONTINUOUS,  // command bit 2
    input wire              VOLT_ONCE,       // command bit 1
    input wire              AMP_ONCE,        // command bit 3
    input wire              DIVIDER_SELECT,  // command bit 4
    input wire              STATUS_SELECT,   // command bit 6
    input wire              ALERT            // alert output
);
    reg       sda_q;
    reg [3:0] stop_age;
    reg [3:0] cause_age;
    wire      stop_seen = SCL && SDA_IN && !sda_q;

    // ages saturate so a stale cause never looks recent
    always @(posedge SYS_CLK) begin
        sda_q <= SDA_IN;
        if (!RST_N)
            stop_age <= 4'hF;
        else if (stop_seen)
            stop_age <= 4'h0;
        else if (stop_age != 4'hF)
            stop_age <= stop_age + 4'h1;
        if (!RST_N)
            cause_age <= 4'hF;
        else if (stop_seen || CONV_DONE || (OC_PRESENT && TIMER_DONE))
            cause_age <= 4'h0;
        else if (cause_age != 4'hF)
            cause_age <= cause_age + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_volt_done;
        VOLT_ONCE && CONV_DONE && !CONV_IS_AMP;
    endsequence
    sequence s_amp_done;
        AMP_ONCE && CONV_DONE && CONV_IS_AMP;
    endsequence
    sequence s_stop_recent;
        stop_age <= 4'h8;
    endsequence

    a_drive_low_only: assert property (SDA_OUT == 1'b0)
        else $error("data drive value not low");
    a_reset_quiet: assert property ($rose(RST_N) |-> !SDA_OE && !READ_NEXT && !ALERT
        && !VOLT_CONTINUOUS && !AMP_CONTINUOUS && !VOLT_ONCE && !AMP_ONCE
        && !DIVIDER_SELECT && !STATUS_SELECT)
        else $error("outputs not idle after reset");
    a_volt_once_clear: assert property (s_volt_done |=> !VOLT_ONCE)
        else $error("voltage one-shot not cleared");
    a_amp_once_clear: assert property (s_amp_done |=> !AMP_ONCE)
        else $error("current one-shot not cleared");
    a_read_next_pulse: assert property (READ_NEXT |=> !READ_NEXT)
        else $error("read strobe longer than one cycle");
    a_ack_low_phase: assert property ($changed(SDA_OE) |-> !SCL)
        else $error("data drive changed while bus clock high");
    a_cmd_after_stop: assert property ($changed({VOLT_CONTINUOUS, AMP_CONTINUOUS,
        DIVIDER_SELECT, STATUS_SELECT}) |-> s_stop_recent)
        else $error("command outputs changed without a stop");
    a_alert_has_cause: assert property ($rose(ALERT) |-> cause_age <= 4'h8)
        else $error("alert rose without a cause");
endmodule // pmi_command_props

bind pmi_command pmi_command_props #(.CODE_W(CODE_W)) u_props (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .ADDR_SEL(ADDR_SEL), .OC_PRESENT(OC_PRESENT),
    .TIMER_DONE(TIMER_DONE), .CONV_DONE(CONV_DONE), .CONV_IS_AMP(CONV_IS_AMP),
    .CONV_CODE(CONV_CODE), .READ_DATA(READ_DATA), .READ_NEXT(READ_NEXT),
    .VOLT_CONTINUOUS(VOLT_CONTINUOUS), .AMP_CONTINUOUS(AMP_CONTINUOUS),
    .VOLT_ONCE(VOLT_ONCE), .AMP_ONCE(AMP_ONCE), .DIVIDER_SELECT(DIVIDER_SELECT),
    .STATUS_SELECT(STATUS_SELECT), .ALERT(ALERT)
);

// ### verif/pmi_command_tb.sv
// self-checking bench for the power monitor command interpreter
// assumes pmi_bus_master as bus master and the checker bound onto the design
`timescale 1ns/1ps
`include "pmi_consts.vh"

module pmi_command_tb;
    reg         sys_clk;
    reg         rst_n;
    reg  [1:0]  addr_sel;
    reg         oc_present;
    reg         timer_done;
    reg         conv_done;
    reg         conv_is_amp;
    reg  [11:0] conv_code;
    reg  [7:0]  read_data;
    reg  [7:0]  adw;
    reg  [7:0]  th;
    reg  [15:0] smp_n;
    integer     errors;
    integer     num_checks;
    integer     i;
    reg  [7:0]  rc;
    reg  [7:0]  rn = 8'h00;
    reg  [7:0]  exp_q[$];
    string      nam_q[$];
    wire        scl;
    wire        m_oe;
    wire        dut_oe;
    wire        sda_out;
    wire        sda = !(m_oe || dut_oe);
    wire [7:0]  rd;
    wire [15:0] res_n;
    wire        read_next, vc, ac, vo, ao, ds, ss, alert;
    wire [7:0]  outs = {alert, ss, 1'b0, ds, ao, ac, vo, vc};

    pmi_command #(.CODE_W(12)) DUT (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(dut_oe), .ADDR_SEL(addr_sel), .OC_PRESENT(oc_present),
        .TIMER_DONE(timer_done), .CONV_DONE(conv_done), .CONV_IS_AMP(conv_is_amp),
        .CONV_CODE(conv_code), .READ_DATA(read_data), .READ_NEXT(read_next),
        .VOLT_CONTINUOUS(vc), .AMP_CONTINUOUS(ac), .VOLT_ONCE(vo), .AMP_ONCE(ao),
        .DIVIDER_SELECT(ds), .STATUS_SELECT(ss), .ALERT(alert)
    );
    pmi_bus_master M (.clk(sys_clk), .sda_in(sda), .scl(scl), .sda_oe(m_oe), .rd(rd),
        .res_n(res_n));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task push(input string n, input [7:0] e);
        nam_q.push_back(n);
        exp_q.push_back(e);
    endtask
    task cmp(input [7:0] v);
        reg [7:0] e;
        string    n;
        num_checks = num_checks + 1;
        if (exp_q.size() == 0) begin
            errors = errors + 1;
            $display("ERROR result expected none seen %h", v);
        end else begin
            e = exp_q.pop_front();
            n = nam_q.pop_front();
            if (v !== e) begin
                errors = errors + 1;
                $display("ERROR %s expected %h seen %h", n, e, v);
            end
        end
    endtask
    always @(res_n) if (res_n != 16'h0000) cmp(rd);
    always @(smp_n) if (smp_n != 16'h0000) cmp(outs);
    always @(negedge sys_clk) if (read_next) rn <= rn + 8'h01;

    task send(input [7:0] b, input [7:0] e, input rx);
        push("bus", e);
        M.xbyte(b, rx, 1'b1);
    endtask
    task wcmd(input [7:0] c);
        M.start;
        send(adw, 8'h00, 1'b0);
        send(c, 8'h00, 1'b0);
        M.stop;
        repeat (10) @(negedge sys_clk);
    endtask
    task wext(input [1:0] sel, input [7:0] d);
        M.start;
        send(adw, 8'h00, 1'b0);
        send({6'h20, sel}, 8'h00, 1'b0);
        send(d, 8'h00, 1'b0);
        M.stop;
        repeat (10) @(negedge sys_clk);
    endtask
    task rd1(input [7:0] ea, input [7:0] ed);
        M.start;
        send(adw | 8'h01, ea, 1'b0);
        if (ea == 8'h00)
            send(8'hFF, ed, 1'b1);
        M.stop;
        repeat (4) @(negedge sys_clk);
    endtask
    task look(input [7:0] e);
        push("ports", e);
        smp_n = smp_n + 16'h0001;
    endtask
    task conv(input a, input [11:0] code);
        conv_is_amp = a;
        conv_code = code;
        conv_done = 1'b1;
        @(negedge sys_clk);
        conv_done = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask
    task finish_test;
        if (exp_q.size() != 0)
            errors = errors + 1;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #1000000;
        errors = errors + 1;
        $display("ERROR watchdog expected done seen timeout");
        finish_test;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        num_checks = 0;
        smp_n = 16'h0000;
        rst_n = 1'b0;
        {oc_present, timer_done, conv_done, conv_is_amp, conv_code} = 16'h0000;
        i = $urandom(32'hB8D0);
        {addr_sel, read_data, th} = 18'($urandom);
        th = {2'b01, th[5:0]};
        adw = {`PMI_ADDR_UPPER, addr_sel, 1'b0};
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        look(8'h00);
        M.start;
        send(adw, 8'h00, 1'b0);
        M.stop;
        M.start;
        send(adw ^ 8'h02, 8'h01, 1'b0);
        M.stop;
        for (i = 0; i < 8; i = i + 1) begin
            rc = (i < 7) ? (8'h75 & (8'h01 << i)) : (8'($urandom) & 8'h75);
            wcmd(rc);
            look(rc & 8'h5F);
        end
        wcmd(8'h04);
        rd1(8'h00, 8'h00);
        conv(1'b1, 12'h000);
        rd1(8'h00, read_data);
        for (i = 0; i < 2; i = i + 1) begin
            wcmd(8'h02 << (2 * i));
            look(8'h02 << (2 * i));
            rd1(8'h01, 8'h00);
            conv(i[0], 12'hFFF);
            look(8'h00);
            rd1(8'h00, read_data);
        end
        wext(`PMI_SEL_THRESHOLD, th);
        wext(`PMI_SEL_ALERT_EN, 8'h01);
        conv(1'b1, {th, 4'hF});
        look(8'h00);
        conv(1'b1, {th + 8'h01, 4'h0});
        look(8'h80);
        wext(`PMI_SEL_ALERT_EN, 8'h11);
        look(8'h00);
        conv(1'b1, {th + 8'h01, 4'h0});
        look(8'h80);
        conv(1'b1, 12'h000);
        wext(`PMI_SEL_ALERT_EN, 8'h12);
        for (i = 0; i < 4; i = i + 1) begin
            conv(1'b1, {th + 8'h01, 4'h0});
            look((i == 3) ? 8'h80 : 8'h00);
        end
        wext(`PMI_SEL_ALERT_EN, 8'h14);
        look(8'h00);
        oc_present = 1'b1;
        repeat (8) @(negedge sys_clk);
        look(8'h00);
        timer_done = 1'b1;
        repeat (8) @(negedge sys_clk);
        look(8'h80);
        {oc_present, timer_done} = 2'b00;
        repeat (8) @(negedge sys_clk);
        look(8'h80);
        wext(`PMI_SEL_ALERT_EN, 8'h14);
        look(8'h00);
        {oc_present, timer_done} = 2'b11;
        repeat (8) @(negedge sys_clk);
        wext(`PMI_SEL_ALERT_EN, 8'h14);
        look(8'h80);
        wext(`PMI_SEL_ALERT_EN, 8'h0C);
        wext(`PMI_SEL_CONTROL, 8'h01);
        look(8'h00);
        wcmd(8'h40);
        look(8'h40);
        rd1(8'h00, 8'h3D);
        wext(`PMI_SEL_ALERT_EN, 8'h04);
        look(8'hC0);
        @(negedge sys_clk);
        push("read strobes", 8'h04);
        cmp(rn);
        finish_test;
    end
endmodule // pmi_command_tb
